//--- design/fsg_pkg.sv
// Purpose: constants and carrier types for the frame statistics and control block
// Assumes: 8-bit register port, 7-bit pixels, 19x19 array
// Notes:   offsets are register addresses on the internal register port
package fsg_pkg;
    localparam logic [7:0] ADDR_MAX_PIXEL  = 8'h08;
    localparam logic [7:0] ADDR_SUM_HIGH   = 8'h09;
    localparam logic [7:0] ADDR_MIN_PIXEL  = 8'h0a;
    localparam logic [7:0] ADDR_GRAB_PORT  = 8'h0b;
    localparam logic [7:0] ADDR_RSVD_0C    = 8'h0c;
    localparam logic [7:0] ADDR_PRIM_CTRL  = 8'h0d;
    localparam logic [7:0] ADDR_SEC_RES    = 8'h19;
    localparam logic [7:0] PRIM_CTRL_RESET = 8'h00;
    localparam logic [7:0] SEC_RES_RESET   = 8'h08;
    localparam int         BIT_PD          = 1;
    localparam int         BIT_RES         = 0;
    localparam int         BIT_RESOLUTION_FIELD_ENABLE      = 4;
    localparam int         GRAB_VALID_BIT  = 7;
    localparam int         SUM_W           = 15;
    localparam int         SUM_HI          = 14;
    localparam int         SUM_LO          = 7;
    localparam logic [14:0] SUM_MAX        = 15'hb317;  // 13079 ceiling, the 15-bit literal drops bit 15 of b317
    localparam int         PIXEL_COUNT     = 361;
    localparam logic [3:0] RES_CODE_MIN    = 4'h1;
    localparam logic [3:0] RES_CODE_MAX    = 4'hb;
    localparam logic [3:0] RES_CODE_500    = 4'h4;
    localparam logic [3:0] RES_CODE_1000   = 4'h8;
    localparam logic [10:0] CPI_STEP       = 11'h07d;   // 125 cpi per code

    typedef struct packed {
        logic       valid;   // one pixel on this cycle
        logic       first;   // first pixel of a frame
        logic       last;    // last pixel of a frame
        logic [6:0] value;
    } fsg_pixel_t;

    typedef struct packed {
        logic       rd;      // one-cycle read strobe
        logic       wr;      // one-cycle write strobe
        logic [7:0] addr;
        logic [7:0] wdata;
    } fsg_reg_req_t;
endpackage : fsg_pkg

//--- design/fsg_grab_slot.sv
// Purpose: one-pixel grab holder with registered read data
// Assumes: pixel stream on clk_sys
// Notes:   holds one word; read data comes out of a register
`timescale 1ns/100ps
module fsg_grab_slot (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic             capture,
    input  wire logic [6:0]       cap_value,
    input  wire logic             consume,
    output logic      [7:0]       rd_word
);
    logic       full_q;
    logic [6:0] value_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            full_q  <= 1'b0;
            value_q <= 7'h00;
        end else if (capture) begin
            full_q  <= 1'b1;
            value_q <= cap_value;
        end else if (consume) begin
            full_q  <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rd_word <= 8'h00;
        end else if (capture) begin
            // mirrors the holder after this edge, so a back-to-back read never sees stale valid
            rd_word <= {1'b1, cap_value};
        end else if (consume) begin
            rd_word <= {1'b0, value_q};
        end
    end
endmodule // fsg_grab_slot

//--- design/fsg_frame_stats.sv
// Purpose: frame statistics, pixel grabber and resolution / power-down control
// Assumes: serial front end delivers one-cycle register strobes on clk_sys
// Notes:   read data registered one cycle after the read strobe
// Operation
// - The brightest pixel of each frame is reported as 0 to 127 and refreshed every frame.
// - All pixels of the last frame are summed into 15 bits and only bits 14..7 are readable.
// - The sum saturates at 13079 so the readable value stays within 0 to 102, per frame.
// - The darkest pixel of each frame is reported as 0 to 127 and refreshed every frame.
// - While armed the grabber takes at most one pixel per frame in array readout order.
// - Reading the grab register with a pixel held returns bit 7 set and pixel, advances, re-arms.
// - Any write to the grab register resets the index and arms for pixel 0 of the next image.
// - The primary control register holds power-down at bit 1 and resolution 500/1000 at bit 0.
// - The secondary resolution field applies only when its enable bit 4 is one.
`timescale 1ns/100ps
module fsg_frame_stats
    import fsg_pkg::*;
#(
    parameter int PIXELS = fsg_pkg::PIXEL_COUNT
) (
    input  wire logic                clk_sys,
    input  wire logic                nrst,
    input  wire fsg_pkg::fsg_pixel_t pix,
    input  wire fsg_pkg::fsg_reg_req_t req,
    output logic      [7:0]          rd_data,
    output logic                     rd_valid,
    output logic                     power_down,
    output logic      [3:0]          res_code,
    output logic      [10:0]         res_cpi
);
    import fsg_pkg::*;

    // the 9-bit index and position counters serve at most 511 pixels
    if (PIXELS < 2 || PIXELS > 511) begin : g_bad_pixels
        $error("PIXELS out of range");
    end

    function automatic logic hit(input fsg_reg_req_t r, input logic [7:0] a);
        return r.addr == a;
    endfunction

    function automatic logic code_ok(input logic [3:0] c);
        return (c >= RES_CODE_MIN) && (c <= RES_CODE_MAX);
    endfunction

    // ---- per-frame statistics
    logic [6:0]       run_max_q, run_min_q, max_q, min_q;
    logic [SUM_W-1:0] run_sum_q, sum_q;
    logic [SUM_W-1:0] sum_next;
    logic [6:0]       max_next, min_next;

    always_comb begin
        if (pix.first) begin
            max_next = pix.value;
            min_next = pix.value;
            sum_next = {8'h00, pix.value};
        end else begin
            max_next = (pix.value > run_max_q) ? pix.value : run_max_q;
            min_next = (pix.value < run_min_q) ? pix.value : run_min_q;
            // saturate so a bright frame never wraps the sum
            if ((SUM_MAX - run_sum_q) < {8'h00, pix.value}) begin
                sum_next = SUM_MAX;
            end else begin
                sum_next = run_sum_q + {8'h00, pix.value};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            run_max_q <= 7'h00;
            run_min_q <= 7'h7f;
            run_sum_q <= '0;
        end else if (pix.valid) begin
            run_max_q <= max_next;
            run_min_q <= min_next;
            run_sum_q <= sum_next;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            max_q <= 7'h00;
            min_q <= 7'h00;
            sum_q <= '0;
        end else if (pix.valid && pix.last) begin
            max_q <= max_next;
            min_q <= min_next;
            sum_q <= sum_next;
        end
    end

    // ---- pixel grabber
    logic [8:0] grab_idx_q;
    logic [8:0] frame_pos_q;
    logic       armed_q;
    logic       wait_frame_q;
    logic       grab_wr, grab_rd, capture, consume;
    logic [7:0] grab_word;

    assign grab_wr = req.wr && hit(req, ADDR_GRAB_PORT);
    assign grab_rd = req.rd && hit(req, ADDR_GRAB_PORT);
    // capture the pixel whose readout position equals the index
    // after a capture or a grab write, wait for the first pixel of a new frame
    assign capture = armed_q && !grab_wr && pix.valid && (!wait_frame_q || pix.first)
                     && (frame_pos_q == grab_idx_q);
    assign consume = grab_rd && grab_word[GRAB_VALID_BIT];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            frame_pos_q <= 9'h000;
        end else if (pix.valid) begin
            frame_pos_q <= pix.last ? 9'h000 : frame_pos_q + 9'h001;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            grab_idx_q   <= 9'h000;
            armed_q      <= 1'b1;
            wait_frame_q <= 1'b1;
        end else if (grab_wr) begin
            grab_idx_q   <= 9'h000;
            armed_q      <= 1'b1;
            wait_frame_q <= 1'b1;
        end else begin
            // a capture closes the frame for grabbing, so gaps in the stream cannot
            // let a second pixel of the same frame in
            if (capture) begin
                wait_frame_q <= 1'b1;
            end else if (pix.valid && pix.first) begin
                wait_frame_q <= 1'b0;
            end
            if (capture) begin
                armed_q <= 1'b0;
            end else if (consume) begin
                armed_q    <= 1'b1;
                grab_idx_q <= (grab_idx_q == 9'(PIXELS - 1)) ? 9'h000
                                                             : grab_idx_q + 9'h001;
            end
        end
    end

    fsg_grab_slot u_slot (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .capture   (capture),
        .cap_value (pix.value),
        .consume   (consume || grab_wr),
        .rd_word   (grab_word)
    );

    // ---- control registers
    logic [1:0] prim_q;
    logic [4:0] sec_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prim_q <= PRIM_CTRL_RESET[1:0];
        end else if (req.wr && hit(req, ADDR_PRIM_CTRL)) begin
            prim_q <= req.wdata[1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sec_q <= SEC_RES_RESET[4:0];
        end else if (req.wr && hit(req, ADDR_SEC_RES)) begin
            sec_q[BIT_RESOLUTION_FIELD_ENABLE] <= req.wdata[BIT_RESOLUTION_FIELD_ENABLE];
            // reserved codes leave the held code alone
            if (code_ok(req.wdata[3:0])) begin
                sec_q[3:0] <= req.wdata[3:0];
            end
        end
    end

    logic [3:0] eff_code;
    always_comb begin
        if (sec_q[BIT_RESOLUTION_FIELD_ENABLE]) begin
            eff_code = sec_q[3:0];
        end else begin
            eff_code = prim_q[BIT_RES] ? RES_CODE_1000 : RES_CODE_500;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            power_down <= 1'b0;
            res_code   <= RES_CODE_500;
            res_cpi    <= 11'h1f4;
        end else begin
            power_down <= prim_q[BIT_PD];
            res_code   <= eff_code;
            res_cpi    <= 11'(CPI_STEP * eff_code);
        end
    end

    // ---- read port
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= req.rd;
            if (req.rd) begin
                unique case (req.addr)
                    ADDR_MAX_PIXEL: rd_data <= {1'b0, max_q};
                    ADDR_SUM_HIGH:  rd_data <= sum_q[SUM_HI:SUM_LO];
                    ADDR_MIN_PIXEL: rd_data <= {1'b0, min_q};
                    ADDR_GRAB_PORT: rd_data <= grab_word;
                    ADDR_PRIM_CTRL: rd_data <= {6'h00, prim_q};
                    default:        rd_data <= 8'h00;
                endcase
            end
        end
    end

    // ---- checks
    sum_bound_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        sum_q <= SUM_MAX) else $error("pixel sum above ceiling");
    grab_valid_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        grab_rd && grab_word[7] |=> rd_data[7] && armed_q) else $error("grab read wrong");
    grab_reset_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        grab_wr |=> grab_idx_q == 9'h000 && armed_q) else $error("grab write no reset");
    res_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !sec_q[4] |=> res_code == (($past(prim_q[0])) ? 4'h8 : 4'h4))
        else $error("resolution ignored primary");
    cpi_map_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        ##1 res_cpi == 11'(125 * res_code)) else $error("cpi map wrong");
    pd_follow_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        req.wr && req.addr == 8'h0d |=> ##1 power_down == $past(req.wdata[1], 2))
        else $error("power down not applied");
    max_min_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        pix.valid && pix.last |=> max_q >= min_q) else $error("max below min");
    one_grab_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        capture |=> !capture [*1]) else $error("two grabs");
endmodule // fsg_frame_stats

//--- bench/fsg_mcu_model.sv
// Purpose: controller model that issues register strobes to the block
// Assumes: strobes launched by non-blocking assignment at a rising edge
// Notes:   grab upload retries up to three times while the valid bit is clear
`timescale 1ns/100ps
module fsg_mcu_model
    import fsg_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic [7:0]       rd_data,
    input  wire logic             rd_valid,
    output fsg_pkg::fsg_reg_req_t req
);
    initial req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        req <= '{1'b0, 1'b1, a, v};
        @(posedge clk_sys);
        req <= '0;
    endtask
    // answer is registered, so look just after the strobe edge, bounded
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        int n;
        @(posedge clk_sys);
        req <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge clk_sys);
        req <= '0;
        #1;
        for (n = 0; n < 3 && rd_valid !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        v = rd_data;
    endtask
    task automatic grab(output logic [7:0] v);
        int n;
        rd(ADDR_GRAB_PORT, v);
        for (n = 0; n < 3 && v[7] !== 1'b1; n++) begin
            rd(ADDR_GRAB_PORT, v);
        end
    endtask
endmodule // fsg_mcu_model

//--- bench/test_frame_stats_pixel_grab_res_ctrl.sv
// Purpose: self-checking bench for frame statistics, grabber and control
// Assumes: short frames through the PIXELS parameter
// Notes:   expectations come from integer models of each frame
`timescale 1ns/100ps
module test_frame_stats_pixel_grab_res_ctrl;
    import fsg_pkg::*;
    localparam int NPIX = 9;
    logic         clk_sys = 0;
    logic         nrst    = 0;
    fsg_pixel_t   pix     = '0;
    fsg_reg_req_t req;
    logic [7:0]   rd_data, d, w;
    logic         rd_valid, power_down;
    logic [3:0]   res_code;
    logic [10:0]  res_cpi;
    int           mismatches = 0;
    int           checks = 0;
    int           seed = 70;
    int           fr[NPIX];
    int           mx, mn, sm, g, k;
    always #4 clk_sys = ~clk_sys;
    fsg_frame_stats #(.PIXELS(NPIX)) dut (.clk_sys(clk_sys), .nrst(nrst), .pix(pix),
        .req(req), .rd_data(rd_data), .rd_valid(rd_valid), .power_down(power_down),
        .res_code(res_code), .res_cpi(res_cpi));
    fsg_mcu_model mcu (.clk_sys(clk_sys), .rd_data(rd_data), .rd_valid(rd_valid),
        .req(req));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // a negative level asks for random pixels
    task automatic frame(input int lvl);
        mx = 0;
        mn = 127;
        sm = 0;
        for (int i = 0; i < NPIX; i++) begin
            fr[i] = (lvl < 0) ? ($random(seed) & 127) : lvl;
            mx = (fr[i] > mx) ? fr[i] : mx;
            mn = (fr[i] < mn) ? fr[i] : mn;
            sm = sm + fr[i];
            @(posedge clk_sys);
            pix <= '{1'b1, i == 0, i == NPIX - 1, fr[i][6:0]};
        end
        @(posedge clk_sys);
        pix <= '0;
        sm = (sm > 45847) ? 45847 : sm;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic stats;
        mcu.rd(ADDR_MAX_PIXEL, d);
        chk("rd_valid", 16'(rd_valid), 16'h0001);
        chk("max_pixel", 16'(d), 16'(mx));
        mcu.rd(ADDR_MIN_PIXEL, d);
        chk("min_pixel", 16'(d), 16'(mn));
        mcu.rd(ADDR_SUM_HIGH, d);
        chk("pixel_sum", 16'(d), 16'(sm >> 7));
    endtask
    task automatic ctl(input int pd, input int cd);
        repeat (3) @(posedge clk_sys);
        chk("power_down", 16'(power_down), 16'(pd));
        chk("res_code", 16'(res_code), 16'(cd));
        chk("res_cpi", 16'(res_cpi), 16'(125 * cd));
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        ctl(0, 4);
        mcu.rd(ADDR_SUM_HIGH, d);
        chk("sum_reset", 16'(d), 16'h0000);
        mcu.rd(ADDR_PRIM_CTRL, d);
        chk("prim_reset", 16'(d), 16'h0000);
        frame(127);
        stats();
        frame(0);
        stats();
        repeat (3) begin
            frame(-1);
            stats();
        end
        mcu.wr(ADDR_GRAB_PORT, 8'($random(seed)));
        mcu.rd(ADDR_GRAB_PORT, d);
        chk("grab_empty", 16'(d[7]), 16'h0000);
        for (k = 0; k < NPIX; k++) begin
            frame(-1);
            g = fr[k];
            // an extra frame while holding must not replace the pixel
            if (k == 2) frame(-1);
            mcu.grab(d);
            chk("grab_pixel", 16'(d), 16'(8'h80 | g));
        end
        mcu.wr(ADDR_GRAB_PORT, 8'h00);
        frame(-1);
        mcu.grab(d);
        chk("grab_rearm", 16'(d), 16'(8'h80 | fr[0]));
        for (k = 0; k < 4; k++) begin
            w = 8'(($random(seed) & 8'hfc) | k);
            mcu.wr(ADDR_PRIM_CTRL, w);
            ctl(k[1], k[0] ? 8 : 4);
            mcu.rd(ADDR_PRIM_CTRL, d);
            chk("prim_read", 16'(d[1:0]), 16'(k));
        end
        mcu.wr(ADDR_PRIM_CTRL, 8'h01);
        mcu.wr(ADDR_SEC_RES, 8'h03);
        ctl(0, 8);
        for (k = 1; k < 12; k++) begin
            mcu.wr(ADDR_SEC_RES, 8'(8'h10 | k));
            ctl(0, k);
        end
        mcu.wr(ADDR_SEC_RES, 8'h10);
        ctl(0, 11);
        mcu.wr(ADDR_SEC_RES, 8'h1c);
        ctl(0, 11);
        mcu.wr(ADDR_SEC_RES, 8'h02);
        ctl(0, 8);
        mcu.rd(ADDR_SEC_RES, d);
        chk("sec_read", 16'(d), 16'h0000);
        mcu.rd(ADDR_RSVD_0C, d);
        chk("rsvd_read", 16'(d), 16'h0000);
        mcu.wr(ADDR_SUM_HIGH, 8'hff);
        mcu.rd(ADDR_SUM_HIGH, d);
        chk("sum_ro", 16'(d), 16'(sm >> 7));
        stop_test();
    end
    // about 15 cycles per grab step and a few hundred more for the rest
    initial begin
        #(8 * 20000);
        mismatches++;
        stop_test();
    end
endmodule // test_frame_stats_pixel_grab_res_ctrl
